// ===== rsp_serial_port.sv
// asynchronous serial port with differential line driver control
`timescale 1ns/100ps
`include "rsp_params.svh"


module rsp_serial_port import rsp_pkg::*; #(
    parameter int FIFO_DEPTH = `RSP_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire rsp_cfg_t cfg,
    input wire logic portEnable,
    input wire logic autoDirEn,
    input wire logic echoOff,
    input wire logic txValid,
    input wire logic [`RSP_CHAR_W-1:0] txData,
    output logic txReady,
    output logic rxValid,
    output rsp_rx_char_t rxChar,
    input wire logic lineRx,
    output logic lineTx,
    output logic lineTxOe,
    output logic ledEnabled,
    output logic ledTx,
    output logic ledRx
);
    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic logic [`RSP_HALVES_W-1:0] stopHalves(input rsp_stop_t s);
        unique case (s)
            RSP_STOP_ONE: return `RSP_HALVES_STOP1;
            RSP_STOP_ONE_HALF: return `RSP_HALVES_STOP15;
            default: return `RSP_HALVES_STOP2;
        endcase
    endfunction

    function automatic logic [2:0] lastBit(input logic [1:0] db);
        return 3'(`RSP_LAST_BIT_BASE + db);
    endfunction

    function automatic logic parityOf(input logic [`RSP_CHAR_W-1:0] d, input logic [1:0] db,
                                      input rsp_parity_t p);
        logic [`RSP_CHAR_W-1:0] mask;
        mask = 8'hFF >> (`RSP_ALIGN_BASE - db);
        return (^(d & mask)) ^ (p == RSP_PAR_ODD);
    endfunction

    // ****************************************************************
    // declarations
    // ****************************************************************
    rsp_tx_state_t txState_q;
    rsp_rx_state_t rxState_q;
    logic [`RSP_DIV_W-1:0] txTmr_q;
    logic [`RSP_DIV_W-1:0] rxTmr_q;
    logic [`RSP_HALVES_W-1:0] txHalves_q;
    logic [`RSP_HALVES_W-1:0] rxHalves_q;
    logic [`RSP_CHAR_W-1:0] txShift_q;
    logic [`RSP_CHAR_W-1:0] rxShift_q;
    logic [2:0] txIdx_q;
    logic [2:0] rxIdx_q;
    logic txPar_q;
    logic rxPar_q;
    logic rxParErr_q;
    logic rxTail_q;
    logic lineTx_q;
    logic lineTxOe_q;
    logic rxValid_q;
    rsp_rx_char_t rxChar_q;
    logic ledEnabled_q;
    logic ledTx_q;
    logic ledRx_q;
    logic fifoValid;
    logic [`RSP_CHAR_W-1:0] fifoData;
    logic txHalf;
    logic rxHalf;
    logic txStep;
    logic rxStep;
    logic txGo;
    logic txLoad;
    logic rxEnable;
    logic rxIdle;

    // ****************************************************************
    // transmit buffer
    // ****************************************************************
    rsp_fifo #(.WIDTH(`RSP_CHAR_W), .DEPTH(FIFO_DEPTH)) txFifo (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .inValid(txValid),
        .inData(txData),
        .inReady(txReady),
        .outValid(fifoValid),
        .outData(fifoData),
        .outReady(txLoad)
    );

    // ****************************************************************
    // transmitter
    // ****************************************************************
    assign rxIdle = (rxState_q == RX_IDLE);
    assign txHalf = (txTmr_q == `RSP_DIV_W'(cfg.halfDiv - 1'b1));
    assign txStep = txHalf && (txHalves_q == `RSP_HALVES_W'(1));
    // two-wire: never start while a character is arriving
    assign txGo = fifoValid && portEnable && !(autoDirEn && (!rxIdle || !lineRx));
    assign txLoad = txGo && (txState_q == TX_IDLE || (txState_q == TX_STOP && txStep));

    always_ff @(posedge core_clk) begin
        if (sys_rst || txState_q == TX_IDLE) begin
            txTmr_q <= '0;
        end else if (txHalf) begin
            txTmr_q <= '0;
        end else begin
            txTmr_q <= txTmr_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            txState_q <= TX_IDLE;
            txHalves_q <= '0;
            txShift_q <= '0;
            txIdx_q <= '0;
            txPar_q <= 1'b0;
            lineTx_q <= 1'b1;
        end else if (txLoad) begin
            txShift_q <= fifoData;
            txPar_q <= parityOf(fifoData, cfg.dataBits, cfg.parity);
            if (autoDirEn && !lineTxOe_q) begin
                txState_q <= TX_LEAD;
                txHalves_q <= `RSP_HALVES_LEAD;
                lineTx_q <= 1'b1;
            end else begin
                txState_q <= TX_START;
                txHalves_q <= `RSP_HALVES_BIT;
                lineTx_q <= 1'b0;
            end
        end else if (txHalf) begin
            txHalves_q <= txHalves_q - 1'b1;
            if (txStep) begin
                unique case (txState_q)
                    TX_LEAD: begin
                        txState_q <= TX_START;
                        txHalves_q <= `RSP_HALVES_BIT;
                        lineTx_q <= 1'b0;
                    end
                    TX_START: begin
                        txState_q <= TX_DATA;
                        txHalves_q <= `RSP_HALVES_BIT;
                        txIdx_q <= '0;
                        lineTx_q <= txShift_q[0];
                    end
                    TX_DATA: begin
                        txHalves_q <= `RSP_HALVES_BIT;
                        if (txIdx_q == lastBit(cfg.dataBits)) begin
                            if (cfg.parity != RSP_PAR_NONE) begin
                                txState_q <= TX_PARITY;
                                lineTx_q <= txPar_q;
                            end else begin
                                txState_q <= TX_STOP;
                                txHalves_q <= stopHalves(cfg.stopBits);
                                lineTx_q <= 1'b1;
                            end
                        end else begin
                            txShift_q <= txShift_q >> 1;
                            txIdx_q <= txIdx_q + 1'b1;
                            lineTx_q <= txShift_q[1];
                        end
                    end
                    TX_PARITY: begin
                        txState_q <= TX_STOP;
                        txHalves_q <= stopHalves(cfg.stopBits);
                        lineTx_q <= 1'b1;
                    end
                    TX_STOP: begin
                        txState_q <= TX_IDLE;
                        lineTx_q <= 1'b1;
                    end
                    TX_IDLE: begin
                        lineTx_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // four-wire drives whenever enabled; two-wire drives only around a burst
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lineTxOe_q <= 1'b0;
        end else if (!autoDirEn) begin
            lineTxOe_q <= portEnable;
        end else if (txLoad && txState_q == TX_IDLE) begin
            lineTxOe_q <= 1'b1;
        end else if (txState_q == TX_IDLE || (txState_q == TX_STOP && txStep && !txGo)
                     || !portEnable) begin
            lineTxOe_q <= 1'b0;
        end
    end

    // ****************************************************************
    // receiver
    // ****************************************************************
    assign rxEnable = portEnable && !(autoDirEn && echoOff && lineTxOe_q);
    assign rxHalf = (rxTmr_q == `RSP_DIV_W'(cfg.halfDiv - 1'b1));
    assign rxStep = rxHalf && (rxHalves_q == `RSP_HALVES_W'(1));

    always_ff @(posedge core_clk) begin
        if (sys_rst || rxState_q == RX_IDLE || rxHalf) begin
            rxTmr_q <= '0;
        end else begin
            rxTmr_q <= rxTmr_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        rxValid_q <= 1'b0;
        if (sys_rst || !rxEnable) begin
            rxState_q <= RX_IDLE;
            rxHalves_q <= '0;
            rxShift_q <= '0;
            rxIdx_q <= '0;
            rxPar_q <= 1'b0;
            rxParErr_q <= 1'b0;
            rxChar_q <= '0;
            rxTail_q <= 1'b0;
            rxValid_q <= 1'b0;
        end else if (rxState_q == RX_IDLE) begin
            if (!lineRx) begin
                rxState_q <= RX_START;
                rxHalves_q <= `RSP_HALVES_LEAD;
            end
        end else if (rxHalf) begin
            rxHalves_q <= rxHalves_q - 1'b1;
            if (rxStep) begin
                rxHalves_q <= `RSP_HALVES_BIT;
                unique case (rxState_q)
                    RX_START: begin
                        rxState_q <= lineRx ? RX_IDLE : RX_DATA;
                        rxIdx_q <= '0;
                        rxPar_q <= (cfg.parity == RSP_PAR_ODD);
                        rxParErr_q <= 1'b0;
                    end
                    RX_DATA: begin
                        rxShift_q <= {lineRx, rxShift_q[`RSP_CHAR_W-1:1]};
                        rxPar_q <= rxPar_q ^ lineRx;
                        rxIdx_q <= rxIdx_q + 1'b1;
                        if (rxIdx_q == lastBit(cfg.dataBits)) begin
                            rxState_q <= (cfg.parity != RSP_PAR_NONE) ? RX_PARITY : RX_STOP;
                        end
                    end
                    RX_PARITY: begin
                        rxParErr_q <= rxPar_q ^ lineRx;
                        rxState_q <= RX_STOP;
                    end
                    RX_STOP: begin
                        if (rxTail_q) begin
                            rxState_q <= RX_IDLE;
                            rxTail_q <= 1'b0;
                        end else begin
                            rxValid_q <= 1'b1;
                            rxChar_q.data <= rxShift_q >> (`RSP_ALIGN_BASE - cfg.dataBits);
                            rxChar_q.parityErr <= rxParErr_q;
                            rxChar_q.frameErr <= !lineRx;
                            // two-wire: the far driver owns the pair until its stop period ends
                            if (autoDirEn && !lineTxOe_q) begin
                                rxTail_q <= 1'b1;
                                rxHalves_q <= stopHalves(cfg.stopBits) - 1'b1;
                            end else begin
                                rxState_q <= RX_IDLE;
                            end
                        end
                    end
                    RX_IDLE: begin
                        rxState_q <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // indicators
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ledEnabled_q <= 1'b0;
            ledTx_q <= 1'b0;
            ledRx_q <= 1'b0;
        end else begin
            ledEnabled_q <= portEnable;
            ledTx_q <= (txState_q != TX_IDLE);
            ledRx_q <= !rxIdle;
        end
    end

    assign lineTx = lineTx_q;
    assign lineTxOe = lineTxOe_q;
    assign rxValid = rxValid_q;
    assign rxChar = rxChar_q;
    assign ledEnabled = ledEnabled_q;
    assign ledTx = ledTx_q;
    assign ledRx = ledRx_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_leadIn;
        txState_q == TX_LEAD ##1 txState_q == TX_LEAD;
    endsequence

    sequence s_leadOut;
        txState_q == TX_STOP && txStep && !txGo && autoDirEn && portEnable;
    endsequence

    a_four_wire_drive: assert property (!autoDirEn |=> lineTxOe_q == $past(portEnable))
        else $error("four-wire driver not following enable");
    a_auto_lead_drive: assert property (s_leadIn |-> lineTxOe_q && lineTx_q)
        else $error("driver off before start bit");
    a_auto_release: assert property (s_leadOut |=> !lineTxOe_q ##1 (!lineTxOe_q || $past(txLoad)))
        else $error("driver held after last stop bit");
    a_echo_off_rx: assert property (autoDirEn && echoOff && lineTxOe_q |-> rxIdle && !rxValid_q)
        else $error("receiver active while driving without echo");
    a_half_duplex: assert property (autoDirEn && $rose(lineTxOe_q) |-> $past(rxIdle))
        else $error("driver enabled during reception");
    a_start_bit_low: assert property (txState_q == TX_START |-> !lineTx_q)
        else $error("start bit not low");
    a_stop_length: assert property ($rose(txState_q == TX_STOP) |->
        txHalves_q == stopHalves(cfg.stopBits) && lineTx_q)
        else $error("stop period length wrong");
    a_parity_after_data: assert property ($rose(txState_q == TX_PARITY) |->
        $past(txState_q) == TX_DATA && cfg.parity != RSP_PAR_NONE)
        else $error("parity bit misplaced");
    a_idle_high: assert property (txState_q == TX_IDLE |-> lineTx_q)
        else $error("idle line not at stop level");
    a_led_enabled: assert property (##1 ledEnabled_q == $past(portEnable))
        else $error("enabled indicator wrong");

endmodule

// ===== rsp_params.svh
// timing, framing and sizing constants of the serial port
`ifndef RSP_PARAMS_SVH
`define RSP_PARAMS_SVH

`define RSP_DIV_W 16
`define RSP_CHAR_W 8
`define RSP_FIFO_DEPTH 16
`define RSP_HALVES_W 3
`define RSP_HALVES_LEAD 3'h1
`define RSP_HALVES_BIT 3'h2
`define RSP_HALVES_STOP1 3'h2
`define RSP_HALVES_STOP15 3'h3
`define RSP_HALVES_STOP2 3'h4
`define RSP_LAST_BIT_BASE 3'h4
`define RSP_ALIGN_BASE 3'h3

`endif

// ===== rsp_pkg.sv
// types shared by the serial port files
`include "rsp_params.svh"

package rsp_pkg;

    typedef enum logic [1:0] {RSP_PAR_NONE, RSP_PAR_EVEN, RSP_PAR_ODD} rsp_parity_t;

    typedef enum logic [1:0] {RSP_STOP_ONE, RSP_STOP_ONE_HALF, RSP_STOP_TWO} rsp_stop_t;

    // dataBits: 0..3 selects five to eight data bits
    typedef struct packed {
        logic [1:0] dataBits;
        rsp_parity_t parity;
        rsp_stop_t stopBits;
        logic [`RSP_DIV_W-1:0] halfDiv;
    } rsp_cfg_t;

    typedef struct packed {
        logic [`RSP_CHAR_W-1:0] data;
        logic parityErr;
        logic frameErr;
    } rsp_rx_char_t;

    typedef enum logic [2:0] {TX_IDLE, TX_LEAD, TX_START, TX_DATA, TX_PARITY, TX_STOP} rsp_tx_state_t;

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rsp_rx_state_t;

endpackage

// ===== rsp_fifo.sv
// transmit character buffer with registered read data
`timescale 1ns/100ps
`include "rsp_params.svh"

module rsp_fifo import rsp_pkg::*; #(
    parameter int WIDTH = `RSP_CHAR_W,
    parameter int DEPTH = `RSP_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic inReady_q;
    logic outValid_q;
    logic [WIDTH-1:0] outData_q;
    logic push;
    logic load;

    function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign push = inValid && inReady_q;
    assign load = (count_q != '0) && (!outValid_q || outReady);
    assign count_d = AW'(0) + count_q + (AW+1)'(push) - (AW+1)'(load);
    assign inReady = inReady_q;
    assign outValid = outValid_q;
    assign outData = outData_q;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            inReady_q <= 1'b0;
        end else begin
            if (push) begin
                wrPtr_q <= nextPtr(wrPtr_q);
            end
            if (load) begin
                rdPtr_q <= nextPtr(rdPtr_q);
            end
            count_q <= count_d;
            inReady_q <= (count_d != (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            outValid_q <= 1'b0;
            outData_q <= '0;
        end else if (load) begin
            outValid_q <= 1'b1;
            outData_q <= mem[rdPtr_q];
        end else if (outReady) begin
            outValid_q <= 1'b0;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge core_clk) disable iff (sys_rst)
        count_q <= (AW+1)'(DEPTH))
        else $error("buffer count above depth");

endmodule

// ===== rsp_remote_model.sv
// remote serial equipment sharing the line with the port
`timescale 1ns/100ps

module rsp_remote_model import rsp_pkg::*; (
    input wire logic core_clk,
    input wire rsp_cfg_t cfg,
    input wire logic twoWire,
    input wire logic lineTx,
    input wire logic lineTxOe,
    output logic remTx,
    output logic remOe
);
    logic [8:0] gotQ[$];
    int errCount = 0;
    int oeCnt = 0;

    initial begin
        remTx = 1'b1;
        remOe = 1'b0;
    end

    function automatic logic parBit(input logic [7:0] d);
        return (cfg.parity == RSP_PAR_ODD) ? ~^d : ^d;
    endfunction

    task automatic waitHalves(input int n);
        repeat (n * int'(cfg.halfDiv)) @(posedge core_clk);
    endtask

    // ****************************************
    // sender: drives its own frame only
    // ****************************************
    task automatic sendChar(input logic [7:0] d, input logic badPar, input logic badStop);
        int nb;
        int hd;
        nb = 5 + int'(cfg.dataBits);
        hd = int'(cfg.halfDiv);
        @(posedge core_clk);
        if (twoWire && lineTxOe !== 1'b0) errCount++;
        remOe <= 1'b1;
        remTx <= 1'b0;
        waitHalves(2);
        for (int i = 0; i < nb; i++) begin
            remTx <= d[i];
            waitHalves(2);
        end
        if (cfg.parity != RSP_PAR_NONE) begin
            remTx <= parBit(d & (8'hFF >> (2'h3 - cfg.dataBits))) ^ badPar;
            waitHalves(2);
        end
        remTx <= ~badStop;
        // a broken stop stays low past the stop sample, then goes high before the receiver samples the false start it sees
        repeat (badStop ? hd + hd / 2 : 0) @(posedge core_clk);
        remTx <= 1'b1;
        repeat (hd * (2 + int'(cfg.stopBits)) - (badStop ? hd + hd / 2 : 0)) @(posedge core_clk);
        remTx <= 1'b1;
        remOe <= 1'b0;
    endtask

    // ****************************************
    // receiver of the port's frames
    // ****************************************
    initial forever begin
        int nb;
        logic [7:0] d;
        logic ok;
        @(posedge core_clk);
        oeCnt = (lineTxOe === 1'b1) ? oeCnt + 1 : 0;
        if (twoWire && lineTxOe === 1'b1 && remOe) errCount++;
        if (lineTxOe === 1'b1 && lineTx === 1'b0) begin
            if (twoWire && oeCnt < int'(cfg.halfDiv)) errCount++;
            nb = 5 + int'(cfg.dataBits);
            d = 8'h00;
            waitHalves(1);
            for (int i = 0; i < nb; i++) begin
                waitHalves(2);
                d[i] = lineTx;
                if (twoWire && lineTxOe !== 1'b1) errCount++;
            end
            ok = 1'b1;
            if (cfg.parity != RSP_PAR_NONE) begin
                waitHalves(2);
                ok = (lineTx === parBit(d));
            end
            waitHalves(2);
            if (lineTx !== 1'b1) ok = 1'b0;
            gotQ.push_back({ok, d});
        end
    end
endmodule

// ===== rsp_serial_port_tb.sv
// self-checking bench of the serial port
`timescale 1ns/100ps

module rsp_serial_port_tb import rsp_pkg::*; ;
    localparam logic [15:0] HD = 16'h0008;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    rsp_cfg_t cfg = '{2'h3, RSP_PAR_NONE, RSP_STOP_ONE, 16'h0008};
    logic portEnable = 1'b0;
    logic autoDirEn = 1'b0;
    logic echoOff = 1'b0;
    logic txValid = 1'b0;
    logic [7:0] txData = 8'h00;
    logic txReady, rxValid, lineRx, lineTx, lineTxOe, ledEnabled, ledTx, ledRx;
    logic remTx, remOe;
    logic sawTx = 1'b0;
    logic sawRx = 1'b0;
    rsp_rx_char_t rxChar;
    rsp_rx_char_t rxQ[$];
    rsp_rx_char_t expRx[$];
    logic [7:0] expTx[$];
    logic [7:0] pat[4] = '{8'h55, 8'hAA, 8'h4F, 8'h4B};
    logic [31:0] seed = 32'h0000F3FA;
    logic [7:0] d, r;
    int fail_count = 0;
    int check_count = 0;

    always #20 core_clk = ~core_clk;

    // the shared pair in two-wire mode, idle bias pulls it high
    assign lineRx = (autoDirEn && lineTxOe) ? lineTx : (remOe ? remTx : 1'b1);

    rsp_serial_port i_rsp_serial_port (.core_clk(core_clk), .sys_rst(sys_rst), .cfg(cfg),
        .portEnable(portEnable), .autoDirEn(autoDirEn), .echoOff(echoOff),
        .txValid(txValid), .txData(txData), .txReady(txReady), .rxValid(rxValid),
        .rxChar(rxChar), .lineRx(lineRx), .lineTx(lineTx), .lineTxOe(lineTxOe),
        .ledEnabled(ledEnabled), .ledTx(ledTx), .ledRx(ledRx));

    rsp_remote_model i_rsp_remote_model (.core_clk(core_clk), .cfg(cfg), .twoWire(autoDirEn),
        .lineTx(lineTx), .lineTxOe(lineTxOe), .remTx(remTx), .remOe(remOe));

    always @(posedge core_clk) begin
        if (rxValid === 1'b1) rxQ.push_back(rxChar);
        if (ledTx === 1'b1) sawTx = 1'b1;
        if (ledRx === 1'b1) sawRx = 1'b1;
    end

    // ****************************************
    // helpers
    // ****************************************
    function logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    function automatic logic [7:0] msk(input logic [7:0] v);
        return v & (8'hFF >> (2'h3 - cfg.dataBits));
    endfunction

    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask

    task automatic test_done();
        fail_count += i_rsp_remote_model.errCount;
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic setCfg(input int db, input int par, input int stp, input int two,
                          input int echo);
        cfg <= '{db[1:0], rsp_parity_t'(par[1:0]), rsp_stop_t'(stp[1:0]), HD};
        autoDirEn <= two[0];
        echoOff <= echo[0];
        repeat (2) @(posedge core_clk);
    endtask

    // leaves the request up so back-to-back writes need no gap
    task automatic writeChar(input logic [7:0] v);
        int n = 0;
        txValid <= 1'b1;
        txData <= v;
        do begin
            @(posedge core_clk);
            n++;
        end while (txReady !== 1'b1 && n < 2000);
        check(n < 2000, "write not accepted");
    endtask

    task automatic waitDone();
        int n = 0;
        while ((i_rsp_remote_model.gotQ.size() < expTx.size() || rxQ.size() < expRx.size())
               && n < 20000) begin
            @(posedge core_clk);
            n++;
        end
        repeat (8 * HD) @(posedge core_clk);
        check(n < 20000, "transfer timed out");
        check(i_rsp_remote_model.gotQ.size() == expTx.size(), "sent count");
        check(rxQ.size() == expRx.size(), "received count");
        foreach (expTx[i]) check(i_rsp_remote_model.gotQ[i] === {1'b1, expTx[i]}, "line char");
        foreach (expRx[i]) check(rxQ[i] === expRx[i], "received char");
        expTx.delete();
        expRx.delete();
        rxQ.delete();
        i_rsp_remote_model.gotQ.delete();
    endtask

    task automatic xfer(input logic [7:0] t, input logic [7:0] v, input logic bp, input logic bs);
        expTx.push_back(msk(t));
        expRx.push_back('{msk(v), bp, bs});
        fork
            begin
                writeChar(t);
                txValid <= 1'b0;
            end
            i_rsp_remote_model.sendChar(v, bp, bs);
        join
        waitDone();
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        check(lineTx === 1'b1 && lineTxOe === 1'b0 && ledEnabled === 1'b0, "reset");
        portEnable <= 1'b1;
        repeat (4) @(posedge core_clk);
        check(ledEnabled === 1'b1 && lineTx === 1'b1, "enabled state");
        foreach (pat[i]) xfer(pat[i], pat[3 - i], 1'b0, 1'b0);
        check(sawTx && sawRx, "traffic indicators");
        for (int db = 0; db < 4; db++)
            for (int p = 0; p < 3; p++)
                for (int s = 0; s < 3; s++) begin
                    setCfg(db, p, s, 0, 0);
                    xfer(rnd(), rnd(), 1'b0, 1'b0);
                end
        setCfg(3, 1, 2, 0, 0);
        xfer(rnd(), rnd(), 1'b1, 1'b0);
        xfer(rnd(), rnd(), 1'b0, 1'b1);
        // fill the buffer while the port is held off, then drain
        setCfg(3, 0, 0, 0, 0);
        portEnable <= 1'b0;
        txValid <= 1'b1;
        txData <= rnd();
        for (int k = 0; k < 24; k++) begin
            @(posedge core_clk);
            if (txReady === 1'b1) begin
                expTx.push_back(txData);
                txData <= rnd();
            end
        end
        txValid <= 1'b0;
        portEnable <= 1'b1;
        check(expTx.size() == 17 && txReady === 1'b0, "buffer capacity");
        waitDone();
        setCfg(3, 1, 0, 1, 0);
        check(lineTxOe === 1'b0, "driver on while idle in two-wire");
        for (int k = 0; k < 3; k++) begin
            d = rnd();
            expTx.push_back(d);
            expRx.push_back('{d, 1'b0, 1'b0});
            writeChar(d);
        end
        txValid <= 1'b0;
        waitDone();
        check(lineTxOe === 1'b0, "driver released after frames");
        setCfg(3, 2, 1, 1, 1);
        d = rnd();
        r = rnd();
        expTx.push_back(d);
        expRx.push_back('{r, 1'b0, 1'b0});
        fork
            i_rsp_remote_model.sendChar(r, 1'b0, 1'b0);
            begin
                repeat (3 * HD) @(posedge core_clk);
                writeChar(d);
                txValid <= 1'b0;
            end
        join
        waitDone();
        test_done();
    end

    initial begin
        #3600000;
        check(1'b0, "run time limit");
        test_done();
    end
endmodule
